// File: pwm_edge_pkg.sv
`default_nettype none
package pwm_edge_pkg;
  typedef logic [11:0] edge_time_t;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic {
    chan_idle,
    chan_resp
  } chan_state_t;
endpackage
`default_nettype wire

// File: pwm_edge_regs.svh
`ifndef PWM_EDGE_REGS_SVH
`define PWM_EDGE_REGS_SVH
// Contract
// - output B rise time is register 0x45 as MSBs and bits [7:4] of 0x46 as LSBs.
// - output B fall time is register 0x47 as MSBs and top nibble of 0x48.
// - output C rise time is register 0x49 as MSBs and top nibble of 0x4A.
// - output C fall time is register 0x4B as MSBs and bits [7:4] of 0x4C.
// - output D rise time is register 0x4D as MSBs and top nibble of 0x4E.
// - one count of an edge time moves the edge by 5 ns.
// - loop modulation shifts an edge only when bit 3 of its setting is one.
// - with modulation enable zero the edge stays at its programmed time.
// - sign bit 2 one: rising modulation moves the edge later.
// - sign bit zero: rising modulation moves the edge earlier.

// register indices; byte address is four times the index
`define OUTPUT_B_RISE_TIME_HIGH_IDX 8'h45
`define OUTPUT_B_RISE_SETTING_IDX 8'h46
`define OUTPUT_B_FALL_TIME_HIGH_IDX 8'h47
`define OUTPUT_B_FALL_SETTING_IDX 8'h48
`define OUTPUT_C_RISE_TIME_HIGH_IDX 8'h49
`define OUTPUT_C_RISE_SETTING_IDX 8'h4A
`define OUTPUT_C_FALL_TIME_HIGH_IDX 8'h4B
`define OUTPUT_C_FALL_SETTING_IDX 8'h4C
`define OUTPUT_D_RISE_TIME_HIGH_IDX 8'h4D
`define OUTPUT_D_RISE_SETTING_IDX 8'h4E
`define EDGE_CONTROL_IDX 8'h60
`define EDGE_STATUS_IDX 8'h61
`define EDGE_REG_COUNT 10
`define EDGE_COUNT 5

// setting register fields
`define SET_LSB_HI 7
`define SET_LSB_LO 4
`define SET_MOD_EN_BIT 3
`define SET_SIGN_BIT 2
`define EDGE_REG_RESET 8'h00

// control and status fields
`define CTRL_RUN_BIT 0
`define CTRL_APPLY_BIT 1
`define CTRL_PERIOD_LO 16
`define CTRL_PERIOD_HI 27
`define PERIOD_RESET 12'hFFF
`define STAT_PENDING_BIT 0
`define STAT_RUN_BIT 1
`define STAT_COUNT_LO 16
`define STAT_COUNT_HI 27

// timing
`define EDGE_STEP_NS 5
`define CLK_PERIOD_NS 25
`define COUNTS_PER_CLK (`CLK_PERIOD_NS / `EDGE_STEP_NS)
`define EDGE_TIME_MAX 14'h0FFF

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: pwm_edge_timing_config.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwm_edge_regs.svh"
module pwm_edge_timing_config #(
  parameter int MOD_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // loop modulation, same clock
  input wire logic [MOD_W-1:0] mod_value,
  // power stage drive
  output logic drive_output_b,
  output logic drive_output_c,
  output logic drive_output_d,
  output logic period_start
);

  // write channel state
  pwm_edge_pkg::chan_state_t wr_state_q, wr_state_d;
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [11:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic [1:0] bresp_q, bresp_d;
  // read channel state
  pwm_edge_pkg::chan_state_t rd_state_q, rd_state_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // register file
  pwm_edge_pkg::reg_byte_t cfg_q [`EDGE_REG_COUNT];
  pwm_edge_pkg::reg_byte_t cfg_d [`EDGE_REG_COUNT];
  logic run_q, run_d;
  logic pending_q, pending_d;
  pwm_edge_pkg::edge_time_t period_q, period_d;
  // active edge set
  pwm_edge_pkg::edge_time_t act_time_q [`EDGE_COUNT];
  pwm_edge_pkg::edge_time_t act_time_d [`EDGE_COUNT];
  logic [`EDGE_COUNT-1:0] act_mod_en_q, act_mod_en_d;
  logic [`EDGE_COUNT-1:0] act_sign_q, act_sign_d;
  logic [MOD_W-1:0] mod_q, mod_d;
  // period counter and outputs
  pwm_edge_pkg::edge_time_t cnt_q, cnt_d;
  logic start_q, start_d;
  logic out_b_q, out_b_d;
  logic out_c_q, out_c_d;
  logic out_d_q, out_d_d;
  // combinational helpers
  logic wr_fire, load_now, last_cnt;
  logic [7:0] wr_idx, rd_idx;
  logic wr_edge_hit, rd_edge_hit;
  logic [7:0] wr_slot, rd_slot;
  logic [12:0] cnt_sum;
  pwm_edge_pkg::edge_time_t eff_time [`EDGE_COUNT], cfg_time [`EDGE_COUNT];
  assign s_axi_awready = !aw_have_q && (wr_state_q == pwm_edge_pkg::chan_idle);
  assign s_axi_wready = !w_have_q && (wr_state_q == pwm_edge_pkg::chan_idle);
  assign s_axi_bvalid = (wr_state_q == pwm_edge_pkg::chan_resp);
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = (rd_state_q == pwm_edge_pkg::chan_idle);
  assign s_axi_rvalid = (rd_state_q == pwm_edge_pkg::chan_resp);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign drive_output_b = out_b_q;
  assign drive_output_c = out_c_q;
  assign drive_output_d = out_d_q;
  assign period_start = start_q;
  assign wr_fire = aw_have_q && w_have_q && (wr_state_q == pwm_edge_pkg::chan_idle);
  assign wr_idx = aw_addr_q[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wr_edge_hit = (aw_addr_q[11:10] == 2'h0) && (wr_idx >= `OUTPUT_B_RISE_TIME_HIGH_IDX)
                       && (wr_idx <= `OUTPUT_D_RISE_SETTING_IDX);
  assign rd_edge_hit = (s_axi_araddr[11:10] == 2'h0) && (rd_idx >= `OUTPUT_B_RISE_TIME_HIGH_IDX)
                       && (rd_idx <= `OUTPUT_D_RISE_SETTING_IDX);
  assign wr_slot = wr_idx - `OUTPUT_B_RISE_TIME_HIGH_IDX;
  assign rd_slot = rd_idx - `OUTPUT_B_RISE_TIME_HIGH_IDX;

  // write channel: address and data taken in either order
  always_comb begin
    wr_state_d = wr_state_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bresp_d = bresp_q;
    case (wr_state_q)
      pwm_edge_pkg::chan_idle: begin
        if (s_axi_awvalid && !aw_have_q) begin
          aw_have_d = 1'b1;
          aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_q) begin
          w_have_d = 1'b1;
          w_data_d = s_axi_wdata;
          w_strb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
          aw_have_d = 1'b0;
          w_have_d = 1'b0;
          wr_state_d = pwm_edge_pkg::chan_resp;
          if (aw_addr_q[1:0] == 2'h0 && aw_addr_q[11:10] == 2'h0 && (wr_edge_hit ||
              wr_idx == `EDGE_CONTROL_IDX || wr_idx == `EDGE_STATUS_IDX)) begin
            bresp_d = `RESP_OKAY;
          end else begin
            bresp_d = `RESP_SLVERR;
          end
        end
      end
      pwm_edge_pkg::chan_resp: begin
        if (s_axi_bready) begin
          wr_state_d = pwm_edge_pkg::chan_idle;
        end
      end
      default: begin
        wr_state_d = pwm_edge_pkg::chan_idle;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= pwm_edge_pkg::chan_idle;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bresp_q <= `RESP_OKAY;
    end else begin
      wr_state_q <= wr_state_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bresp_q <= bresp_d;
    end
  end

  // register file writes; reserved bits of the edge registers stored as written, control register keeps only run and period
  always_comb begin
    for (int i = 0; i < `EDGE_REG_COUNT; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    run_d = run_q;
    period_d = period_q;
    pending_d = pending_q;
    if (load_now) begin
      pending_d = 1'b0;
    end
    if (wr_fire && aw_addr_q[1:0] == 2'h0) begin
      if (wr_edge_hit && w_strb_q[0]) begin
        cfg_d[wr_slot[3:0]] = w_data_q[7:0];
      end
      if (wr_idx == `EDGE_CONTROL_IDX && aw_addr_q[11:10] == 2'h0) begin
        if (w_strb_q[0]) begin
          run_d = w_data_q[`CTRL_RUN_BIT];
          if (w_data_q[`CTRL_APPLY_BIT]) begin
            pending_d = 1'b1;
          end
        end
        if (w_strb_q[2]) begin
          period_d[7:0] = w_data_q[`CTRL_PERIOD_LO+7:`CTRL_PERIOD_LO];
        end
        if (w_strb_q[3]) begin
          period_d[11:8] = w_data_q[`CTRL_PERIOD_HI:`CTRL_PERIOD_LO+8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `EDGE_REG_COUNT; i++) begin
        cfg_q[i] <= `EDGE_REG_RESET;
      end
      run_q <= 1'b0;
      period_q <= `PERIOD_RESET;
      pending_q <= 1'b0;
    end else begin
      for (int i = 0; i < `EDGE_REG_COUNT; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
      run_q <= run_d;
      period_q <= period_d;
      pending_q <= pending_d;
    end
  end

  // read channel
  always_comb begin
    rd_state_d = rd_state_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    case (rd_state_q)
      pwm_edge_pkg::chan_idle: begin
        if (s_axi_arvalid) begin
          rd_state_d = pwm_edge_pkg::chan_resp;
          rdata_d = 32'h00000000;
          rresp_d = `RESP_OKAY;
          if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr[11:10] != 2'h0) begin
            rresp_d = `RESP_SLVERR;
          end else if (rd_edge_hit) begin
            rdata_d[7:0] = cfg_q[rd_slot[3:0]];
          end else if (rd_idx == `EDGE_CONTROL_IDX) begin
            rdata_d[`CTRL_RUN_BIT] = run_q;
            rdata_d[`CTRL_PERIOD_HI:`CTRL_PERIOD_LO] = period_q;
          end else if (rd_idx == `EDGE_STATUS_IDX) begin
            rdata_d[`STAT_PENDING_BIT] = pending_q;
            rdata_d[`STAT_RUN_BIT] = run_q;
            rdata_d[`STAT_COUNT_HI:`STAT_COUNT_LO] = cnt_q;
          end else begin
            rresp_d = `RESP_SLVERR;
          end
        end
      end
      pwm_edge_pkg::chan_resp: begin
        if (s_axi_rready) begin
          rd_state_d = pwm_edge_pkg::chan_idle;
        end
      end
      default: begin
        rd_state_d = pwm_edge_pkg::chan_idle;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= pwm_edge_pkg::chan_idle;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else begin
      rd_state_q <= rd_state_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // per edge: assemble time, apply modulation with saturation
  genvar e;
  generate
    for (e = 0; e < `EDGE_COUNT; e++) begin : g_edge
      logic [13:0] base_ext;
      logic [13:0] mod_ext;
      logic [13:0] later;
      assign cfg_time[e] = {cfg_q[2*e], cfg_q[2*e+1][`SET_LSB_HI:`SET_LSB_LO]};
      assign base_ext = {2'h0, act_time_q[e]};
      assign mod_ext = 14'(mod_q);
      assign later = base_ext + mod_ext;
      always_comb begin
        if (!act_mod_en_q[e]) begin
          eff_time[e] = act_time_q[e];
        end else if (act_sign_q[e]) begin
          eff_time[e] = (later > `EDGE_TIME_MAX) ? 12'hFFF : later[11:0];
        end else begin
          eff_time[e] = (mod_ext > base_ext) ? 12'h000 : 12'(base_ext - mod_ext);
        end
      end
    end
  endgenerate

  // active set and modulation load whole on the last count before the wrap, or while stopped
  assign cnt_sum = {1'b0, cnt_q} + 13'(`COUNTS_PER_CLK);
  assign last_cnt = run_q && ({1'b0, cnt_d} + 13'(`COUNTS_PER_CLK) > {1'b0, period_q});
  assign load_now = pending_q && (!run_q || last_cnt);
  always_comb begin
    for (int i = 0; i < `EDGE_COUNT; i++) begin
      act_time_d[i] = act_time_q[i];
    end
    act_mod_en_d = act_mod_en_q;
    act_sign_d = act_sign_q;
    mod_d = mod_q;
    if (last_cnt || !run_q) begin
      mod_d = mod_value;
    end
    if (load_now) begin
      for (int i = 0; i < `EDGE_COUNT; i++) begin
        act_time_d[i] = cfg_time[i];
        act_mod_en_d[i] = cfg_q[2*i+1][`SET_MOD_EN_BIT];
        act_sign_d[i] = cfg_q[2*i+1][`SET_SIGN_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `EDGE_COUNT; i++) begin
        act_time_q[i] <= 12'h000;
      end
      act_mod_en_q <= '0;
      act_sign_q <= '0;
      mod_q <= '0;
    end else begin
      for (int i = 0; i < `EDGE_COUNT; i++) begin
        act_time_q[i] <= act_time_d[i];
      end
      act_mod_en_q <= act_mod_en_d;
      act_sign_q <= act_sign_d;
      mod_q <= mod_d;
    end
  end

  // period counter in 5 ns units and edge comparison
  always_comb begin
    cnt_d = cnt_q;
    start_d = 1'b0;
    out_b_d = 1'b0;
    out_c_d = 1'b0;
    out_d_d = 1'b0;
    if (run_q) begin
      if (cnt_sum > {1'b0, period_q}) begin
        cnt_d = 12'h000;
        start_d = 1'b1;
      end else begin
        cnt_d = cnt_sum[11:0];
      end
      out_b_d = (cnt_d >= eff_time[0]) && (cnt_d < eff_time[1]);
      out_c_d = (cnt_d >= eff_time[2]) && (cnt_d < eff_time[3]);
      out_d_d = (cnt_d >= eff_time[4]);
    end else begin
      cnt_d = 12'h000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 12'h000;
      start_q <= 1'b0;
      out_b_q <= 1'b0;
      out_c_q <= 1'b0;
      out_d_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      start_q <= start_d;
      out_b_q <= out_b_d;
      out_c_q <= out_c_d;
      out_d_q <= out_d_d;
    end
  end

endmodule
`default_nettype wire

// File: pwm_edge_timing_config_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwm_edge_regs.svh"
module pwm_edge_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive side
  input wire logic drive_output_d,
  input wire logic period_start
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  pulse_one_a: assert property (period_start |=> !period_start)
    else $error("period pulse too long");
  d_fall_a: assert property ($fell(drive_output_d) |-> period_start || $past(period_start))
    else $error("output d fell inside period");
endmodule
bind pwm_edge_timing_config pwm_edge_checker u_checker (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .drive_output_d(drive_output_d), .period_start(period_start)
);
`default_nettype wire

// File: pwm_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
module pwm_stage_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // gate drive inputs
  input wire logic drive_output_b,
  input wire logic drive_output_c,
  input wire logic drive_output_d,
  input wire logic period_start,
  // on-time per period in clocks, b c d
  output logic [23:0] width_q,
  output logic done_q
);
  logic [23:0] cnt_q, cnt_d, now_d;
  always_comb begin
    now_d = {7'h0, drive_output_b, 7'h0, drive_output_c, 7'h0, drive_output_d};
    cnt_d = (period_start === 1'h1) ? now_d : cnt_q + now_d;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 24'h0;
      width_q <= 24'h0;
      done_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      width_q <= (period_start === 1'h1) ? cnt_q : width_q;
      done_q <= period_start === 1'h1;
    end
  end
endmodule
`default_nettype wire

// File: test_pwm_edge_timing_config.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwm_edge_regs.svh"
module test_pwm_edge_timing_config;
  localparam int PER = 200;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] mod_value = 8'h0;
  logic drive_output_b, drive_output_c, drive_output_d, period_start, done_q;
  logic [23:0] width_q;
  logic [5:0] seen;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [23:0] wq[$];
  int n_errors = 0;
  int num_checks = 0;
  always #12.5 aclk = ~aclk;
  pwm_edge_timing_config u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .mod_value(mod_value), .drive_output_b(drive_output_b), .drive_output_c(drive_output_c),
    .drive_output_d(drive_output_d), .period_start(period_start)
  );
  pwm_stage_model u_stage (
    .aclk(aclk), .aresetn(aresetn), .drive_output_b(drive_output_b), .drive_output_c(drive_output_c),
    .drive_output_d(drive_output_d), .period_start(period_start), .width_q(width_q), .done_q(done_q)
  );
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic void chk(string s, logic [33:0] e, logic [33:0] g);
    num_checks++;
    if (e !== g) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endfunction
  // outputs as they will stand at the coming rising edge
  always @(negedge aclk) begin
    seen <= {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, done_q};
    if (s_axi_rvalid === 1'h1 && s_axi_rready && rq.size() > 0) chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'h1 && s_axi_bready && bq.size() > 0) chk("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
    if (done_q === 1'h1 && wq.size() > 0) chk("widths", 34'(wq.pop_front()), 34'(width_q));
  end
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 400) begin
      n_errors++;
      $display("unexpected wait: expected %0d seen %0d", 400, n);
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic a, w;
    n = 0;
    a = 1'h1;
    w = 1'h1;
    bq.push_back(r);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (a || w) begin
      step(n);
      a = a && seen[5] !== 1'h1;
      w = w && seen[4] !== 1'h1;
      s_axi_awvalid <= a;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1'h1;
    do step(n); while (seen[3] !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [33:0] e);
    int n;
    n = 0;
    rq.push_back(e);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    do step(n); while (seen[2] !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do step(n); while (seen[1] !== 1'h1);
    s_axi_rready <= 1'h0;
  endtask
  task automatic meas(input logic [23:0] e);
    int n;
    n = 0;
    repeat (2) do step(n); while (seen[0] !== 1'h1);
    wq.push_back(e);
    do step(n); while (seen[0] !== 1'h1);
  endtask
  function automatic int mt(int b, logic [7:0] s, int m);
    if (!s[`SET_MOD_EN_BIT]) return b;
    if (s[`SET_SIGN_BIT]) return (b + m > 4095) ? 4095 : b + m;
    return (b < m) ? 0 : b - m;
  endfunction
  function automatic logic [7:0] hw(int r, int f);
    logic [7:0] n;
    n = 8'h0;
    for (int k = 0; k * `COUNTS_PER_CLK <= PER; k++) n += 8'(k * `COUNTS_PER_CLK >= r && k * `COUNTS_PER_CLK < f);
    return n;
  endfunction
  initial begin
    logic [7:0] s;
    logic [7:0] v[10];
    logic [23:0] x;
    int t[5];
    int m;
    void'($urandom(32'hC7DF));
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int i = 8'h45; i <= 8'h4E; i++) rd(8'(i), 34'h0);
    rd(8'h60, 34'h0FFF0000);
    rd(8'h50, {`RESP_SLVERR, 32'h0});
    wr(8'h50, 32'hFF, `RESP_SLVERR);
    $display("test reset_and_map done");
    for (int c = 0; c < 3; c++) begin
      s = {4'h0, c != 0, c == 1, 2'h0};
      m = $urandom_range(15, 1);
      t = '{$urandom_range(60), 100 + $urandom_range(60), $urandom_range(60), 100 + $urandom_range(60), 20 + $urandom_range(150)};
      for (int e = 0; e < 5; e++) begin
        v[2 * e] = 8'(t[e] >> 4);
        v[2 * e + 1] = {4'(t[e]), s[3:0]};
      end
      mod_value <= 8'(m);
      for (int r = 0; r < 10; r++) wr(8'h45 + 8'(r), {24'h0, v[r]}, `RESP_OKAY);
      for (int r = 0; r < 10; r++) rd(8'h45 + 8'(r), {26'h0, v[r]});
      wr(8'h60, 32'h00C80003, `RESP_OKAY);
      x = {hw(mt(t[0], s, m), mt(t[1], s, m)), hw(mt(t[2], s, m), mt(t[3], s, m)), hw(mt(t[4], s, m), PER + 1)};
      meas(x);
      wr(8'h45, 32'h0000000A, `RESP_OKAY);
      meas(x);
      $display("test edge_case %0d done", c);
    end
    summarize();
  end
endmodule
`default_nettype wire
